//--- rtl/alzb_pkg.sv
// Purpose: constants for the ambient light zone brightness block
// Assumes: 8-bit sensor codes arrive from an external converter
// Notes:
// Functional notes
// [R01] four programmable zone boundaries, five zones
// [R02] each zone has its own brightness target
// [R03] config [6:5] picks max, average, a, b
// [R04] config [4:3] switches sensing on or off
// [R05] config [2:0] selects averaging time
// [R06] compare sensed value to four 8-bit boundaries
// [R07] ramp brightness gradually to new target; code ramps in zone mode only, register mode jumps straight to brt_q
// [R08] status bit 3 sets on every zone change
// [R09] reading status clears the change flag
// [R10] status [2:0] reports the active zone
// [R11] fifteen load resistor settings plus high-z
// [R12] select bit picks register or zone brightness
// [R13] pwm enable scales current by duty cycle
// [R14] host holds pwm high for enable time
// [R15] host holds pwm low for disable time
// [R16] host drives serial lines glitch free
// [R17] boundary codes below 0x03 act as 0x03
// [R18] averager starts from a zone 0 reading
// [R19] non-integer zone average rounds down
// [R20] sample inputs at 16 kHz, accumulate per period
// [R21] zone index counts boundaries exceeded, 0 to 4; code gives one above the highest-numbered boundary exceeded
package alzb_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int SAMPLE_HZ = 16_000;
   localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int RAMP_HZ = 16_000;
   localparam int RAMP_DIV = CLK_HZ / RAMP_HZ;
   localparam int PWM_EN_US = 1500;
   localparam int PWM_DIS_US = 1480;
   localparam int PWM_EN_CYC = (PWM_EN_US * (CLK_HZ / 1_000_000));
   localparam int PWM_DIS_CYC = (PWM_DIS_US * (CLK_HZ / 1_000_000));
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CFG_SEL_LSB = 5;
   localparam int CFG_EN_LSB = 3;
   localparam int STAT_FLAG_BIT = 3;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] ZB_MIN = 8'h03;
   localparam logic [1:0] SEL_MAX = 2'h0;
   localparam logic [1:0] SEL_AVG = 2'h1;
   localparam logic [1:0] SEL_A = 2'h2;
   localparam logic [1:0] SEL_B = 2'h3;
   localparam logic [3:0] RES_HIGHZ = 4'h0;
endpackage

//--- rtl/alzb_averager.sv
// Purpose: accumulates zone samples and emits floor of the average
// Assumes: period is a power of two of samples
// Notes: sum divided by shift, which rounds down
`timescale 1ns/100ps
`default_nettype none
module alzb_averager
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic run,
   input wire logic sample_en,
   input wire logic [2:0] zone_in,
   input wire logic [2:0] time_sel,
   output logic [2:0] zone_avg,
   output logic done
);
   logic [22:0] sum_q, sum_d;
   logic [18:0] cnt_q, cnt_d;
   logic [2:0] avg_q, avg_d;
   logic done_q, done_d;
   logic [18:0] len;
   logic [4:0] sh;
   // period length 2^(time_sel+5) samples
   always_comb
   begin
      sh = 5'(time_sel) + 5'h05; // [R05]
      len = 19'(19'h00001 << sh);
      sum_d = sum_q;
      cnt_d = cnt_q;
      avg_d = avg_q;
      done_d = 1'b0;
      if (!run)
      begin
         sum_d = 23'h000000;
         cnt_d = 19'h00000;
      end
      else if (sample_en)
      begin
         if (cnt_q >= len - 19'h00001)
         begin
            avg_d = 3'((sum_q + 23'(zone_in)) >> sh); // [R19] [R20]
            sum_d = 23'h000000;
            cnt_d = 19'h00000;
            done_d = 1'b1;
         end
         else
         begin
            sum_d = sum_q + 23'(zone_in); // [R20]
            cnt_d = cnt_q + 19'h00001;
         end
      end
   end
   // register stage, zone 0 at start
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sum_q <= 23'h000000;
         cnt_q <= 19'h00000;
         avg_q <= 3'h0; // [R18]
         done_q <= 1'b0;
      end
      else
      begin
         sum_q <= sum_d;
         cnt_q <= cnt_d;
         avg_q <= avg_d;
         done_q <= done_d;
      end
   end
   assign zone_avg = avg_q;
   assign done = done_q;
endmodule // alzb_averager
`default_nettype wire

//--- rtl/alzb_top.sv
// Purpose: zone detection, brightness select, ramp and pwm enable
// Assumes: registers written through a decoded write port
// Notes: sensor values are 8-bit codes from an external converter
`timescale 1ns/100ps
`default_nettype none
module alzb_top
#(
   parameter int PWM_EN_CYCLES = alzb_pkg::PWM_EN_CYC,
   parameter int PWM_DIS_CYCLES = alzb_pkg::PWM_DIS_CYC
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] light_sensor_input_a,
   input wire logic [7:0] light_sensor_input_b,
   input wire logic pwm_in,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic zb_we,
   input wire logic [1:0] zb_idx,
   input wire logic zt_we,
   input wire logic [2:0] zt_idx,
   input wire logic [7:0] reg_wdata,
   input wire logic brt_we,
   input wire logic ctl_we,
   input wire logic [7:0] ctl_wdata,
   input wire logic res_we,
   input wire logic [7:0] res_wdata,
   input wire logic stat_re,
   output logic [7:0] ambient_sense_config,
   output logic [7:0] ambient_zone_status,
   output logic [3:0] res_sel_a,
   output logic [3:0] res_sel_b,
   output logic [6:0] brightness_code,
   output logic pwm_scale_en,
   output logic device_enabled
);
   // ************************************************************
   // register file
   // ************************************************************
   logic [7:0] cfg_q, cfg_d;
   logic [7:0] zb_q [4];
   logic [7:0] zb_d [4];
   logic [6:0] zt_q [5];
   logic [6:0] zt_d [5];
   logic [6:0] brt_q, brt_d;
   logic zsel_q, zsel_d;
   logic pwmen_q, pwmen_d;
   logic [7:0] res_q, res_d;
   logic sense_on;
   logic [1:0] in_sel;

   // next register values from write strobes
   always_comb
   begin
      cfg_d = cfg_q;
      brt_d = brt_q;
      zsel_d = zsel_q;
      pwmen_d = pwmen_q;
      res_d = res_q;
      zb_d = zb_q;
      zt_d = zt_q;
      if (cfg_we)
         cfg_d = cfg_wdata;
      if (brt_we)
         brt_d = reg_wdata[6:0];
      if (ctl_we)
      begin
         zsel_d = ctl_wdata[0];
         pwmen_d = ctl_wdata[1];
      end
      if (res_we)
         res_d = res_wdata; // [R11]
      if (zb_we)
         zb_d[zb_idx] = reg_wdata; // [R01]
      if (zt_we && zt_idx < 3'h5)
         zt_d[zt_idx] = reg_wdata[6:0]; // [R02]
   end

   // register stage
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cfg_q <= alzb_pkg::CFG_RESET;
         brt_q <= 7'h00;
         zsel_q <= 1'b0;
         pwmen_q <= 1'b0;
         res_q <= {alzb_pkg::RES_HIGHZ, alzb_pkg::RES_HIGHZ};
         for (int i = 0; i < 4; i++)
            zb_q[i] <= 8'h00;
         for (int i = 0; i < 5; i++)
            zt_q[i] <= 7'h00;
      end
      else
      begin
         cfg_q <= cfg_d;
         brt_q <= brt_d;
         zsel_q <= zsel_d;
         pwmen_q <= pwmen_d;
         res_q <= res_d;
         zb_q <= zb_d;
         zt_q <= zt_d;
      end
   end

   assign in_sel = cfg_q[alzb_pkg::CFG_SEL_LSB +: 2];
   assign sense_on = |cfg_q[alzb_pkg::CFG_EN_LSB +: 2]; // [R04]
   assign res_sel_a = res_q[3:0]; // [R11]
   assign res_sel_b = res_q[7:4];

   // ************************************************************
   // sensed value and instantaneous zone
   // ************************************************************
   function automatic logic [7:0] alzb_eff_zb(input logic [7:0] v);
      alzb_eff_zb = (v < alzb_pkg::ZB_MIN) ? alzb_pkg::ZB_MIN : v; // [R17]
   endfunction

   logic [7:0] sensed;
   logic [8:0] sum_ab;
   logic [2:0] zone_now;
   // active input mux
   always_comb
   begin
      sum_ab = {1'b0, light_sensor_input_a} + {1'b0, light_sensor_input_b};
      unique case (in_sel) // [R03]
         alzb_pkg::SEL_MAX:
            sensed = (light_sensor_input_a > light_sensor_input_b) ?
                     light_sensor_input_a : light_sensor_input_b;
         alzb_pkg::SEL_AVG:
            sensed = sum_ab[8:1];
         alzb_pkg::SEL_A:
            sensed = light_sensor_input_a;
         alzb_pkg::SEL_B:
            sensed = light_sensor_input_b;
      endcase
   end

   // zone is one above the highest-numbered boundary exceeded
   always_comb
   begin
      zone_now = 3'h0;
      for (int i = 0; i < 4; i++)
         if (sensed > alzb_eff_zb(zb_q[i])) // [R06]
            zone_now = 3'(i + 1); // [R21]
   end

   // ************************************************************
   // sample and ramp dividers
   // ************************************************************
   logic [15:0] sdiv_q, sdiv_d;
   logic [15:0] rdiv_q, rdiv_d;
   logic sample_en, ramp_en;
   always_comb
   begin
      sample_en = (sdiv_q == 16'(alzb_pkg::SAMPLE_DIV - 1)); // [R20]
      ramp_en = (rdiv_q == 16'(alzb_pkg::RAMP_DIV - 1));
      sdiv_d = sample_en ? 16'h0000 : sdiv_q + 16'h0001;
      rdiv_d = ramp_en ? 16'h0000 : rdiv_q + 16'h0001;
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sdiv_q <= 16'h0000;
         rdiv_q <= 16'h0000;
      end
      else
      begin
         sdiv_q <= sdiv_d;
         rdiv_q <= rdiv_d;
      end
   end

   logic [2:0] zone_avg;
   logic avg_done;
   alzb_averager alzb_averager_inst
   (
      .mclk(mclk),
      .rst(rst),
      .run(sense_on),
      .sample_en(sample_en),
      .zone_in(zone_now),
      .time_sel(cfg_q[2:0]),
      .zone_avg(zone_avg),
      .done(avg_done)
   );

   // ************************************************************
   // active zone and status flag
   // ************************************************************
   logic [2:0] zone_q, zone_d;
   logic flag_q, flag_d;
   logic zone_chg;
   always_comb
   begin
      zone_d = zone_q;
      zone_chg = 1'b0;
      if (avg_done && zone_avg != zone_q)
      begin
         zone_d = zone_avg;
         zone_chg = 1'b1;
      end
      flag_d = flag_q;
      if (stat_re)
         flag_d = 1'b0; // [R09]
      if (zone_chg)
         flag_d = 1'b1; // [R08]
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         zone_q <= 3'h0;
         flag_q <= 1'b0;
      end
      else
      begin
         zone_q <= zone_d;
         flag_q <= flag_d;
      end
   end
   assign ambient_sense_config = cfg_q;
   assign ambient_zone_status = {4'h0, flag_q, zone_q}; // [R10]

   // ************************************************************
   // brightness select and ramp
   // ************************************************************
   logic [6:0] target;
   logic [6:0] code_q, code_d;
   always_comb
   begin
      target = zsel_q ? zt_q[zone_q] : brt_q; // [R12]
      code_d = code_q;
      if (!zsel_q)
         code_d = brt_q;
      else if (ramp_en && code_q < target)
         code_d = code_q + 7'h01; // [R07]
      else if (ramp_en && code_q > target)
         code_d = code_q - 7'h01; // [R07]
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
         code_q <= 7'h00;
      else
         code_q <= code_d;
   end
   assign brightness_code = code_q;
   assign pwm_scale_en = pwmen_q; // [R13]

   // ************************************************************
   // simple enable / disable through pwm pin
   // ************************************************************
   logic [15:0] hold_q, hold_d;
   logic pin_q, pin_d;
   logic en_q, en_d;
   always_comb
   begin
      pin_d = pwm_in;
      hold_d = (pwm_in != pin_q) ? 16'h0000 :
               (hold_q == 16'hFFFF ? hold_q : hold_q + 16'h0001);
      en_d = en_q;
      if (pin_q && hold_q >= 16'(PWM_EN_CYCLES - 1))
         en_d = 1'b1; // [R14]
      if (!pin_q && hold_q >= 16'(PWM_DIS_CYCLES - 1))
         en_d = 1'b0; // [R15]
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         hold_q <= 16'h0000;
         pin_q <= 1'b0;
         en_q <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
         pin_q <= pin_d;
         en_q <= en_d;
      end
   end
   assign device_enabled = en_q;
endmodule // alzb_top
`default_nettype wire

//--- dv/alzb_assertions.sv
// Purpose: port checks for alzb_top
// Assumes: bound from the bench top
// Notes: pwm hold counts come in as parameters
`timescale 1ns/100ps
`default_nettype none
module alzb_assertions
#(
   parameter int PWM_EN_CYCLES = 20,
   parameter int PWM_DIS_CYCLES = 20
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic pwm_in,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic ctl_we,
   input wire logic [7:0] ctl_wdata,
   input wire logic res_we,
   input wire logic [7:0] res_wdata,
   input wire logic stat_re,
   input wire logic [7:0] ambient_sense_config,
   input wire logic [7:0] ambient_zone_status,
   input wire logic [3:0] res_sel_a,
   input wire logic [3:0] res_sel_b,
   input wire logic [6:0] brightness_code,
   input wire logic pwm_scale_en,
   input wire logic device_enabled
);
   logic [15:0] hi_q, hi_d, lo_q, lo_d;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // pwm high and low run lengths
   always_comb
   begin
      hi_d = pwm_in ? hi_q + {15'h0000, hi_q != 16'hFFFF} : 16'h0000;
      lo_d = !pwm_in ? lo_q + {15'h0000, lo_q != 16'hFFFF} : 16'h0000;
   end
   always_ff @(posedge mclk)
   begin
      hi_q <= rst ? 16'h0000 : hi_d;
      lo_q <= rst ? 16'h0000 : lo_d;
   end
   // ************************************************************
   // properties
   // ************************************************************
   a_reset_clear: assert property (disable iff (1'b0) rst |=>
      ambient_zone_status == 8'h00 && brightness_code == 7'h00)
      else $error("outputs not clear after reset");
   a_cfg_write: assert property (cfg_we |=>
      ambient_sense_config == $past(cfg_wdata))
      else $error("config write lost");
   a_res_write: assert property (res_we |=>
      {res_sel_b, res_sel_a} == $past(res_wdata))
      else $error("resistor write lost");
   a_pwm_bit: assert property (ctl_we |=>
      pwm_scale_en == $past(ctl_wdata[1]))
      else $error("pwm scale bit wrong");
   a_flag_set: assert property ($changed(ambient_zone_status[2:0])
      |-> ##[0:1] ambient_zone_status[3])
      else $error("zone change without flag");
   a_flag_clear: assert property ($stable(ambient_zone_status[2:0]) [*3]
      ##0 stat_re ##1 $stable(ambient_zone_status[2:0])
      |-> !ambient_zone_status[3])
      else $error("flag not cleared by read");
   a_zone_range: assert property (
      ambient_zone_status[2:0] <= 3'h4 && ambient_zone_status[7:4] == 4'h0)
      else $error("zone index out of range");
   a_enable_hold: assert property ($rose(device_enabled)
      |-> hi_q >= PWM_EN_CYCLES - 1)
      else $error("enabled before pwm high time");
   a_disable_hold: assert property ($fell(device_enabled)
      |-> lo_q >= PWM_DIS_CYCLES - 1)
      else $error("disabled before pwm low time");
   c_flag_read: cover property (stat_re && ambient_zone_status[3]);
   c_enable: cover property ($rose(device_enabled));
   c_disable: cover property ($fell(device_enabled));
endmodule // alzb_assertions
`default_nettype wire

//--- dv/alzb_light_model.sv
// Purpose: sensor converter codes and pwm pin of the far side
// Assumes: codes are already digitised levels
// Notes: pins move only on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module alzb_light_model
(
   input wire logic mclk,
   input wire logic [7:0] level_a,
   input wire logic [7:0] level_b,
   input wire logic pwm_req,
   output logic [7:0] light_sensor_input_a,
   output logic [7:0] light_sensor_input_b,
   output logic pwm_in
);
   // glitch free pin updates, single driver per pin
   always @(negedge mclk)
   begin
      light_sensor_input_a <= level_a;
      light_sensor_input_b <= level_b;
      pwm_in <= pwm_req;
   end
endmodule // alzb_light_model
`default_nettype wire

//--- dv/alzb_top_test.sv
// Purpose: register, zone, ramp and pwm tests of alzb_top
// Assumes: short pwm hold counts
// Notes: zone waits are bounded
`timescale 1ns/100ps
`default_nettype none
module alzb_top_test;
   localparam int EN_CYC = 20;
   localparam int DIS_CYC = 20;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] lvl_a = 8'h00, lvl_b = 8'h00, sens_a, sens_b;
   logic pwm_req = 1'b0, pwm_in, ramp_on = 1'b0;
   logic cfg_we = 1'b0, zb_we = 1'b0, zt_we = 1'b0, brt_we = 1'b0;
   logic ctl_we = 1'b0, res_we = 1'b0, stat_re = 1'b0;
   logic [7:0] cfg_wdata = 8'h00, reg_wdata = 8'h00;
   logic [7:0] ctl_wdata = 8'h00, res_wdata = 8'h00;
   logic [1:0] zb_idx = 2'h0;
   logic [2:0] zt_idx = 3'h0;
   logic [7:0] ambient_sense_config, ambient_zone_status;
   logic [3:0] res_sel_a, res_sel_b;
   logic [6:0] brightness_code, prev_code;
   logic pwm_scale_en, device_enabled;
   logic [7:0] zb_tab [4] = '{8'h00, 8'h20, 8'h30, 8'h40};
   logic [7:0] zt_tab [5] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06};
   logic [1:0] sel_tab [4] = '{alzb_pkg::SEL_A, alzb_pkg::SEL_B,
      alzb_pkg::SEL_AVG, alzb_pkg::SEL_MAX};
   logic [2:0] zexp [4] = '{3'h3, 3'h0, 3'h1, 3'h3};
   int err_count = 0;
   int num_checks = 0;
   alzb_light_model alzb_light_model_inst (.mclk(mclk), .level_a(lvl_a),
      .level_b(lvl_b), .pwm_req(pwm_req), .light_sensor_input_a(sens_a),
      .light_sensor_input_b(sens_b), .pwm_in(pwm_in));
   alzb_top #(.PWM_EN_CYCLES(EN_CYC), .PWM_DIS_CYCLES(DIS_CYC)) alzb_top_inst
   (
      .mclk(mclk), .rst(rst), .light_sensor_input_a(sens_a),
      .light_sensor_input_b(sens_b), .pwm_in(pwm_in), .cfg_we(cfg_we),
      .cfg_wdata(cfg_wdata), .zb_we(zb_we), .zb_idx(zb_idx), .zt_we(zt_we),
      .zt_idx(zt_idx), .reg_wdata(reg_wdata), .brt_we(brt_we),
      .ctl_we(ctl_we), .ctl_wdata(ctl_wdata), .res_we(res_we),
      .res_wdata(res_wdata), .stat_re(stat_re),
      .ambient_sense_config(ambient_sense_config),
      .ambient_zone_status(ambient_zone_status), .res_sel_a(res_sel_a),
      .res_sel_b(res_sel_b), .brightness_code(brightness_code),
      .pwm_scale_en(pwm_scale_en), .device_enabled(device_enabled)
   );
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // k: 0 cfg, 1 boundary, 2 target, 3 brightness, 4 ctl, 5 resistor
   task automatic wr(input int k, input logic [2:0] i, input logic [7:0] d);
      @(negedge mclk);
      {cfg_wdata, reg_wdata, ctl_wdata, res_wdata} = {4{d}};
      zb_idx = i[1:0];
      zt_idx = i;
      {cfg_we, zb_we, zt_we} = {k == 0, k == 1, k == 2};
      {brt_we, ctl_we, res_we} = {k == 3, k == 4, k == 5};
      @(negedge mclk);
      {cfg_we, zb_we, zt_we, brt_we, ctl_we, res_we} = 6'h00;
   endtask
   task automatic wait_zone(input logic [2:0] z);
      int n;
      n = 0;
      while (ambient_zone_status[2:0] !== z && n < 21000)
      begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      chk(ambient_zone_status, {5'h01, z});
      stat_re = 1'b1;
      @(negedge mclk);
      stat_re = 1'b0;
      chk(ambient_zone_status, {5'h00, z});
   endtask
   task automatic pwm_len(input logic v, input int n);
      @(negedge mclk);
      pwm_req = v;
      repeat (n) @(negedge mclk);
      pwm_req = !v;
      repeat (4) @(negedge mclk);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ************************************************************
   // clock, watchdog, ramp monitor, tests
   // ************************************************************
   initial
   begin
      forever #50 mclk = !mclk;
   end
   initial
   begin
      repeat (99000) @(posedge mclk);
      err_count++;
      finish_test();
   end
   // brightness moves one code at a time, sampled once settled
   always @(negedge mclk)
   begin
      if (ramp_on)
         chk({7'h00, brightness_code - prev_code <= 7'h01 ||
            prev_code - brightness_code == 7'h01}, 8'h01);
      prev_code <= brightness_code;
   end
   initial
   begin
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk(ambient_zone_status, 8'h00);
      chk({1'b0, brightness_code}, 8'h00);
      chk({7'h00, device_enabled}, 8'h00);
      for (int i = 0; i < 4; i++) wr(1, i[2:0], zb_tab[i]);
      for (int i = 0; i < 5; i++) wr(2, i[2:0], zt_tab[i]);
      wr(2, 3'h5, 8'h7F);
      wr(5, 3'h0, 8'h4C);
      chk({res_sel_b, res_sel_a}, 8'h4C);
      wr(4, 3'h0, 8'h01);
      $display("test registers done");
      lvl_a = 8'h35;
      lvl_b = 8'h02;
      ramp_on = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         // sensing off restarts the averaging period from empty
         wr(0, 3'h0, {1'b0, sel_tab[m], 5'h00});
         wr(0, 3'h0, {1'b0, sel_tab[m], 5'h08});
         chk(ambient_sense_config, {1'b0, sel_tab[m], 5'h08});
         wait_zone(zexp[m]);
         repeat (2600) @(negedge mclk);
         chk({1'b0, brightness_code}, zt_tab[zexp[m]]);
         $display("test mode %0d done", m);
      end
      ramp_on = 1'b0;
      wr(4, 3'h0, 8'h02);
      wr(3, 3'h0, 8'h55);
      @(negedge mclk);
      chk({1'b0, brightness_code}, 8'h55);
      chk({7'h00, pwm_scale_en}, 8'h01);
      pwm_len(1'b1, 5);
      chk({7'h00, device_enabled}, 8'h00);
      pwm_len(1'b1, EN_CYC + 10);
      chk({7'h00, device_enabled}, 8'h01);
      pwm_len(1'b0, 5);
      chk({7'h00, device_enabled}, 8'h01);
      pwm_len(1'b0, DIS_CYC + 10);
      chk({7'h00, device_enabled}, 8'h00);
      $display("test pwm done");
      finish_test();
   end
endmodule // alzb_top_test
bind alzb_top alzb_assertions #(.PWM_EN_CYCLES(PWM_EN_CYCLES),
   .PWM_DIS_CYCLES(PWM_DIS_CYCLES)) alzb_assertions_inst
(
   .mclk(mclk), .rst(rst), .pwm_in(pwm_in), .cfg_we(cfg_we),
   .cfg_wdata(cfg_wdata), .ctl_we(ctl_we), .ctl_wdata(ctl_wdata),
   .res_we(res_we), .res_wdata(res_wdata), .stat_re(stat_re),
   .ambient_sense_config(ambient_sense_config),
   .ambient_zone_status(ambient_zone_status), .res_sel_a(res_sel_a),
   .res_sel_b(res_sel_b), .brightness_code(brightness_code),
   .pwm_scale_en(pwm_scale_en), .device_enabled(device_enabled)
);
`default_nettype wire
